/* hw/fdmc_defines.vh */
// Purpose: constants for the fractional divider modulation control block
// Assumes: configuration word is 40 bits, loaded as a whole
// Notes:   bit positions refer to the 40-bit configuration word
`ifndef FDMC_DEFINES_VH
`define FDMC_DEFINES_VH
`define FDMC_CFG_W          40
`define FDMC_CFG_RESET      40'h0000000000
`define FDMC_SCALE_HI       36
`define FDMC_SCALE_LO       32
`define FDMC_MOD_ORDER_HI   31
`define FDMC_MOD_ORDER_LO   29
`define FDMC_BAND_HI        28
`define FDMC_BAND_LO        24
`define FDMC_DITH_ORDER_HI  2
`define FDMC_DITH_ORDER_LO  0
`define FDMC_FRAC_W         28
`define FDMC_INT_W          8
`define FDMC_MAX_ORDER      3'h4
`define FDMC_MAX_DITH       3'h5
`define FDMC_INTERP_NONE    2'h3
`define FDMC_LFSR_SEED      16'hACE1
`endif

/* hw/fdmc_mod_ctrl.v */
// Purpose: noise-shaping modulator and dither for a fractional-N feedback divider
// Assumes: clk is the divider feedback clock; one ratio per enabled cycle
// Notes:   configuration is loaded whole through cfg_we; serial port lives outside
`timescale 1ns/1ns
`default_nettype none
`include "fdmc_defines.vh"

module fdmc_mod_ctrl #(
  parameter FRAC_W = 28,
  parameter INT_W  = 8
) (
  input  wire                   clk,
  input  wire                   resetn,
  input  wire                   clk_en,
  input  wire                   cfg_we,
  input  wire [39:0]            cfg_wdata,
  input  wire [INT_W-1:0]       divider_integer,
  input  wire [FRAC_W-1:0]      fractional_divider_word,
  input  wire [1:0]             interp_order,
  input  wire                   divider_reset,
  output wire [39:0]            cfg_rdata,
  output reg  [INT_W:0]         divider_ratio,
  output reg  [2:0]             phase_fraction,
  output reg  [4:0]             vco_band_select,
  output reg                    modulating
);

  // reset release through two flops
  reg rst_s1_r;
  reg rst_s2_r;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;

  // configuration register
  reg [39:0] pll2_modulation_config_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pll2_modulation_config_r <= `FDMC_CFG_RESET;
    else if (clk_en && cfg_we)
      pll2_modulation_config_r <= cfg_wdata;
  end
  assign cfg_rdata = pll2_modulation_config_r;

  wire [2:0] modulator_order     = pll2_modulation_config_r[`FDMC_MOD_ORDER_HI:`FDMC_MOD_ORDER_LO];
  wire [4:0] dither_scale        = pll2_modulation_config_r[`FDMC_SCALE_HI:`FDMC_SCALE_LO];
  wire [2:0] noise_shaping_order = pll2_modulation_config_r[`FDMC_DITH_ORDER_HI:`FDMC_DITH_ORDER_LO];

  // clamp orders to usable range; larger codes are a software fault
  wire [2:0] mord = (modulator_order > `FDMC_MAX_ORDER) ? `FDMC_MAX_ORDER : modulator_order;
  wire [2:0] dord = (noise_shaping_order > `FDMC_MAX_DITH) ? `FDMC_MAX_DITH : noise_shaping_order;

  // phase bits kept by interpolation: eight phases keep 3, none keep 0
  function [FRAC_W-1:0] fdmc_interp_mask;
    input [1:0] code;
    begin
      case (code)
        2'h0:    fdmc_interp_mask = {3'h7, {(FRAC_W-3){1'b0}}};
        2'h1:    fdmc_interp_mask = {3'h6, {(FRAC_W-3){1'b0}}};
        2'h2:    fdmc_interp_mask = {3'h4, {(FRAC_W-3){1'b0}}};
        default: fdmc_interp_mask = {FRAC_W{1'b0}};
      endcase
    end
  endfunction

  wire [FRAC_W-1:0] coarse_mask = fdmc_interp_mask(interp_order);
  wire [FRAC_W-1:0] frac_coarse = fractional_divider_word & coarse_mask;
  wire [FRAC_W-1:0] frac_fine   = fractional_divider_word & ~coarse_mask;
  wire              exact       = (frac_fine == {FRAC_W{1'b0}});
  wire              mod_on      = (mord != 3'h0) && !exact;

  // random source for dither
  reg [15:0] lfsr_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      lfsr_r <= `FDMC_LFSR_SEED;
    else if (clk_en)
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
  end

  // shaped dither: order-n difference of a random bit, so sum is bounded and mean is zero
  reg  [4:0] rbit_hist_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rbit_hist_r <= 5'h00;
    else if (clk_en)
      rbit_hist_r <= {rbit_hist_r[3:0], lfsr_r[0]};
  end

  // binomial difference weights up to order five; one 7-bit signed width serves every order
  reg signed [6:0] dith_raw;
  always @* begin
    case (dord)
      3'h1:    dith_raw = $signed({6'h00, lfsr_r[0]}) - $signed({6'h00, rbit_hist_r[0]});
      3'h2:    dith_raw = $signed({6'h00, lfsr_r[0]}) - 7'sd2 * $signed({6'h00, rbit_hist_r[0]})
                          + $signed({6'h00, rbit_hist_r[1]});
      3'h3:    dith_raw = $signed({6'h00, lfsr_r[0]}) - 7'sd3 * $signed({6'h00, rbit_hist_r[0]})
                          + 7'sd3 * $signed({6'h00, rbit_hist_r[1]})
                          - $signed({6'h00, rbit_hist_r[2]});
      3'h4:    dith_raw = $signed({6'h00, lfsr_r[0]}) - 7'sd4 * $signed({6'h00, rbit_hist_r[0]})
                          + 7'sd6 * $signed({6'h00, rbit_hist_r[1]})
                          - 7'sd4 * $signed({6'h00, rbit_hist_r[2]})
                          + $signed({6'h00, rbit_hist_r[3]});
      3'h5:    dith_raw = $signed({6'h00, lfsr_r[0]}) - 7'sd5 * $signed({6'h00, rbit_hist_r[0]})
                          + 7'sd10 * $signed({6'h00, rbit_hist_r[1]})
                          - 7'sd10 * $signed({6'h00, rbit_hist_r[2]})
                          + 7'sd5 * $signed({6'h00, rbit_hist_r[3]})
                          - $signed({6'h00, rbit_hist_r[4]});
      default: dith_raw = 7'sd0;
    endcase
  end

  // scaled dither added to the fine fraction, in a wide signed accumulator space
  localparam AW = FRAC_W + 4;
  wire signed [AW-1:0] dith_ext    = {{(AW-7){dith_raw[6]}}, dith_raw};
  wire signed [AW-1:0] dith_scaled = dith_ext <<< dither_scale;
  wire signed [AW-1:0] frac_in     = $signed({4'h0, frac_fine})
                                     + ((mod_on && dord != 3'h0) ? dith_scaled : {AW{1'b0}});

  // MASH cascade of up to four accumulators; carries combined by difference filters
  reg  [FRAC_W-1:0] acc_r [0:3];
  wire [FRAC_W-1:0] acc_in  [0:3];
  wire [FRAC_W:0]   acc_sum [0:3];
  wire [3:0]        cy;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : stage
      if (g == 0) begin : first
        assign acc_in[g] = frac_in[FRAC_W-1:0];
      end else begin : next
        assign acc_in[g] = acc_sum[g-1][FRAC_W-1:0];
      end
      assign acc_sum[g] = {1'b0, acc_r[g]} + {1'b0, acc_in[g]};
      assign cy[g] = (g < mord) ? acc_sum[g][FRAC_W] : 1'b0;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          acc_r[g] <= {FRAC_W{1'b0}};
        else if (clk_en) begin
          if (divider_reset || !mod_on || g >= mord)
            acc_r[g] <= {FRAC_W{1'b0}};
          else
            acc_r[g] <= acc_sum[g][FRAC_W-1:0];
        end
      end
    end
  endgenerate

  // carry history for the difference network
  reg [3:0] cy_d1_r;
  reg [3:0] cy_d2_r;
  reg [3:0] cy_d3_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cy_d1_r <= 4'h0;
      cy_d2_r <= 4'h0;
      cy_d3_r <= 4'h0;
    end else if (clk_en) begin
      cy_d1_r <= cy;
      cy_d2_r <= cy_d1_r;
      cy_d3_r <= cy_d2_r;
    end
  end

  // combined offset: c1 + (1-z)c2 + (1-z)^2 c3 + (1-z)^3 c4, zero mean around the fraction
  wire signed [4:0] off = $signed({4'h0, cy[0]})
                        + $signed({4'h0, cy[1]}) - $signed({4'h0, cy_d1_r[1]})
                        + $signed({4'h0, cy[2]}) - 5'sd2 * $signed({4'h0, cy_d1_r[2]})
                        + $signed({4'h0, cy_d2_r[2]})
                        + $signed({4'h0, cy[3]}) - 5'sd3 * $signed({4'h0, cy_d1_r[3]})
                        + 5'sd3 * $signed({4'h0, cy_d2_r[3]}) - $signed({4'h0, cy_d3_r[3]});

  // higher orders spread beyond floor/ceiling momentarily; first order stays strictly within
  wire signed [INT_W+1:0] ratio_s = $signed({2'b00, divider_integer})
                                  + {{(INT_W-3){off[4]}}, off};

  // ratio output, one per feedback cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divider_ratio   <= {(INT_W+1){1'b0}};
      phase_fraction  <= 3'h0;
      vco_band_select <= 5'h00;
      modulating      <= 1'b0;
    end else if (clk_en) begin
      divider_ratio   <= mod_on ? ratio_s[INT_W:0] : {1'b0, divider_integer};
      phase_fraction  <= frac_coarse[FRAC_W-1:FRAC_W-3];
      vco_band_select <= pll2_modulation_config_r[`FDMC_BAND_HI:`FDMC_BAND_LO];
      modulating      <= mod_on;
    end
  end

endmodule
`default_nettype wire

/* tb/fdmc_mod_ctrl_properties.sv */
// Purpose: port assertions for the modulation control block
// Assumes: derived outputs follow the config register one edge later
// Notes:   checks wait a few edges for the internal reset copy
`timescale 1ns/1ns
`default_nettype none
module fdmc_mod_ctrl_properties #(
  parameter FRAC_W = 28,
  parameter INT_W  = 8
) (
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              clk_en,
  input wire logic              cfg_we,
  input wire logic [39:0]       cfg_wdata,
  input wire logic [INT_W-1:0]  divider_integer,
  input wire logic [FRAC_W-1:0] fractional_divider_word,
  input wire logic              divider_reset,
  input wire logic [39:0]       cfg_rdata,
  input wire logic [INT_W:0]    divider_ratio,
  input wire logic [4:0]        vco_band_select,
  input wire logic              modulating
);
  logic [1:0] age_r;
  wire        live = (age_r == 2'h3);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // outputs sit at zero while the internal reset copy drains
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) age_r <= 2'h0;
    else if (!live) age_r <= age_r + 2'h1;
  sequence s_steady;
    live && clk_en && !cfg_we && !divider_reset && $stable(cfg_rdata);
  endsequence
  sequence s_run2;
    live && clk_en ##1 clk_en;
  endsequence
  a_cfg_load: assert property (
    live && clk_en && cfg_we |=> cfg_rdata == $past(cfg_wdata))
    else $error("config load wrong");
  a_cfg_hold: assert property (
    live && !(clk_en && cfg_we) |=> $stable(cfg_rdata))
    else $error("config changed");
  a_band_copy: assert property (
    s_run2 |-> vco_band_select == $past(cfg_rdata[28:24]))
    else $error("band field wrong");
  a_mod_off: assert property (
    s_steady ##0 cfg_rdata[31:29] == 3'h0
    |=> !modulating && divider_ratio == $past(divider_integer))
    else $error("ratio modulated at order zero");
  a_order_one: assert property (
    s_steady ##0 cfg_rdata[31:29] == 3'h1
    |=> divider_ratio - $past(divider_integer) <= 1)
    else $error("ratio off floor and ceiling");
  a_exact_int: assert property (
    s_steady ##0 fractional_divider_word == 0 && $past(divider_reset)
    |=> !modulating && divider_ratio == $past(divider_integer))
    else $error("integer ratio modulated");
  a_mod_needed: assert property (
    s_steady ##0 cfg_rdata[31:29] != 3'h0 && fractional_divider_word[0] |=> modulating)
    else $error("modulation missing");
  a_gated_hold: assert property (
    live && !clk_en |=> $stable(divider_ratio) && $stable(vco_band_select))
    else $error("state moved while gated");
endmodule
bind fdmc_mod_ctrl fdmc_mod_ctrl_properties #(.FRAC_W(FRAC_W), .INT_W(INT_W)) u_props (
  .clk(clk), .resetn(resetn), .clk_en(clk_en), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
  .divider_integer(divider_integer), .fractional_divider_word(fractional_divider_word),
  .divider_reset(divider_reset), .cfg_rdata(cfg_rdata), .divider_ratio(divider_ratio),
  .vco_band_select(vco_band_select), .modulating(modulating));
`default_nettype wire

/* tb/fdmc_mod_ctrl_bench.sv */
// Purpose: directed bench for the modulation control block
// Assumes: inputs change on the falling edge
// Notes:   averages span whole pattern periods
`timescale 1ns/1ns
`default_nettype none
module fdmc_mod_ctrl_bench;
  logic        clk, resetn, clk_en, cfg_we, divider_reset;
  logic [39:0] cfg_wdata;
  logic [7:0]  divider_integer;
  logic [27:0] fractional_divider_word;
  logic [1:0]  interp_order;
  wire  [39:0] cfg_rdata;
  wire  [8:0]  divider_ratio;
  wire  [4:0]  vco_band_select;
  wire         modulating;
  wire  [2:0]  phase_fraction;
  int          err_count, checked, sum, k;
  logic [4:0]  bands [5] = '{5'h00, 5'h0D, 5'h0E, 5'h1B, 5'h1F};
  fdmc_mod_ctrl dut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .cfg_we(cfg_we),
    .cfg_wdata(cfg_wdata), .divider_integer(divider_integer),
    .fractional_divider_word(fractional_divider_word), .interp_order(interp_order),
    .divider_reset(divider_reset), .cfg_rdata(cfg_rdata), .divider_ratio(divider_ratio),
    .phase_fraction(phase_fraction), .vco_band_select(vco_band_select), .modulating(modulating));
  // divider clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [39:0] cw(input logic [4:0] sc, input logic [2:0] mo,
                                     input logic [4:0] bd, input logic [2:0] dt);
    return {3'h0, sc, mo, bd, 21'h0, dt};
  endfunction
  // whole-word write, then a divider reset pulse so old accumulators never leak
  task automatic wr(input logic [39:0] w);
    cfg_we = 1'b1;
    cfg_wdata = w;
    @(negedge clk);
    cfg_we = 1'b0;
    divider_reset = 1'b1;
    @(negedge clk);
    divider_reset = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // sum of ratio minus integer over n cycles, against a tolerance
  task automatic meas(input int n, input int exp, input int tol);
    sum = 0;
    repeat (n) begin
      @(negedge clk);
      sum += int'(divider_ratio) - int'(divider_integer);
    end
    chk("ratio sum", 40'(sum >= exp - tol && sum <= exp + tol), 40'h1);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    cfg_we = 1'b0;
    divider_reset = 1'b0;
    cfg_wdata = 40'h0;
    interp_order = 2'h2;
    divider_integer = 8'h64;
    fractional_divider_word = 28'h0;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    chk("cfg reset", cfg_rdata, 40'h0);
    // band codes either side of the gain-range switch points
    foreach (bands[b]) begin
      wr(cw(5'h00, 3'h0, bands[b], 3'h0));
      chk("band", vco_band_select, bands[b]);
    end
    // order zero drops the bit finer than two phases
    fractional_divider_word = 28'h8000001;
    wr(cw(5'h00, 3'h0, 5'h00, 3'h0));
    chk("ratio", divider_ratio, 9'h064);
    chk("modulating", modulating, 1'b0);
    chk("phase fraction", phase_fraction, 3'h4);
    interp_order = 2'h3;
    fractional_divider_word = 28'h4000001;
    // each order averages a quarter; first order without dither is exact
    for (k = 1; k <= 4; k++) begin
      wr(cw(5'h14, k[2:0], 5'h00, 3'h0));
      chk("modulating", modulating, 1'b1);
      meas(1024, 256, (k == 1) ? 1 : 4);
    end
    // dither of every order must leave the average where it was
    for (k = 1; k <= 5; k++) begin
      wr(cw(5'h14, (k > 4) ? 3'h4 : k[2:0], 5'h00, k[2:0]));
      meas(1024, 256, 8);
    end
    // integer divider needs no modulation even with an order set
    fractional_divider_word = 28'h0;
    wr(cw(5'h00, 3'h2, 5'h00, 3'h0));
    chk("modulating", modulating, 1'b0);
    chk("ratio", divider_ratio, 9'h064);
    // a write with the clock gated is lost
    clk_en = 1'b0;
    wr(cw(5'h00, 3'h1, 5'h1F, 3'h0));
    clk_en = 1'b1;
    @(negedge clk);
    chk("cfg gated", cfg_rdata, cw(5'h00, 3'h2, 5'h00, 3'h0));
    print_verdict;
  end
endmodule
`default_nettype wire
